//--- hdl/down_timer.sv
// Built-in down timer of the processor core.
// Assumes load/start strobes come from core logic on ref_clk.
// What this block does
// - Two modes, count-down and interrupt, shared counting.
// - Preload by software, count only after start.
// - Decrement once every divider cycles while running.
// - Count-down mode holds at zero, never wraps.
// - Count-down underflow sets status word bit 12.
// - Interrupt mode raises interrupt on reaching zero.
`timescale 1ns/1ps
`default_nettype none
module down_timer #(
   parameter int count_clock_divider = down_timer_pkg::DIVIDER_DEFAULT
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Software command
   input wire down_timer_pkg::timer_cmd_t cmd,
   // Status word flag clear (one-cycle pulse)
   input wire logic underflow_clear,
   // Timer state
   output logic [down_timer_pkg::COUNT_WIDTH-1:0] count,
   output logic running,
   output logic [down_timer_pkg::STATUS_WIDTH-1:0] processor_status_word,
   output logic timer_irq
);
   import down_timer_pkg::*;

   localparam int DIV_WIDTH = $clog2(count_clock_divider + 1);
   localparam logic [DIV_WIDTH-1:0] DIV_LAST =
      DIV_WIDTH'(count_clock_divider - 1);
   localparam logic [DIV_WIDTH-1:0] DIV_ZERO = '0;
   // Only the underflow bit of the status word is owned here
   localparam logic [STATUS_WIDTH-1:0] UNDERFLOW_MASK =
      STATUS_WIDTH'(1) << UNDERFLOW_BIT;

   // Divider of one or more only, refused at elaboration
   if (count_clock_divider < 1) begin : g_bad_divider
      $error("count_clock_divider must be at least one");
   end

   // Status word must be wide enough to hold the underflow bit
   if (UNDERFLOW_BIT >= STATUS_WIDTH) begin : g_bad_status
      $error("status word too narrow for the underflow bit");
   end

   timer_state_t state;
   timer_mode_t mode;
   logic [DIV_WIDTH-1:0] div_cnt;
   logic timer_underflow_flag;

   wire tick = (state == ST_RUN) && (div_cnt == DIV_LAST);
   wire reaching_zero = tick && (count == COUNT_ONE);
   wire start_zero = cmd.start && (count == COUNT_ZERO) && !cmd.load;
   wire hit_zero = reaching_zero || ((state == ST_RUN) && count == COUNT_ZERO);
   wire [DIV_WIDTH-1:0] next_div = tick ? DIV_ZERO : div_cnt + 1'b1;
   wire set_underflow = hit_zero && (mode == MODE_COUNT_DOWN);
   wire set_irq = hit_zero && (mode == MODE_INTERRUPT);

   // Next flag value, shared by the flag and the status word copy
   // Set wins over clear, so an underflow is never lost
   wire next_underflow = set_underflow ||
      (timer_underflow_flag && !underflow_clear);
   wire [STATUS_WIDTH-1:0] next_status =
      next_underflow ? UNDERFLOW_MASK : '0;

   // Running output: a load or a zero count ends the run
   wire next_running = (state == ST_RUN) && !hit_zero && !cmd.load;

   // Count value and load
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count <= COUNT_ZERO;
         mode <= MODE_COUNT_DOWN;
      end else if (cmd.load) begin
         count <= cmd.preload;
         mode <= cmd.mode;
      end else if (tick && count != COUNT_ZERO) begin
         count <= count - COUNT_ONE;
      end
   end

   // Run state: idle until started, expired holds zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         div_cnt <= DIV_ZERO;
      end else begin
         case (state)
            ST_IDLE, ST_EXPIRED: begin
               div_cnt <= DIV_ZERO;
               if (cmd.start && !cmd.load && !start_zero) begin
                  state <= ST_RUN;
               end else if (cmd.load) begin
                  state <= ST_IDLE;
               end
            end
            ST_RUN: begin
               div_cnt <= next_div;
               if (cmd.load) begin
                  state <= ST_IDLE;
               end else if (hit_zero) begin
                  state <= ST_EXPIRED;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Sticky underflow flag, set beats clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         timer_underflow_flag <= 1'b0;
      end else begin
         timer_underflow_flag <= next_underflow;
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         timer_irq <= 1'b0;
         running <= 1'b0;
         processor_status_word <= '0;
      end else begin
         timer_irq <= set_irq;
         running <= next_running;
         processor_status_word <= next_status;
      end
   end

   // Last decrement of a run, not overridden by a load
   sequence s_last_tick;
      reaching_zero && !cmd.load;
   endsequence

   // A start that the timer must accept
   sequence s_start_taken;
      (state != ST_RUN) && cmd.start && !cmd.load && (count != COUNT_ZERO);
   endsequence

   // A start that must be refused because the count is zero
   sequence s_start_refused;
      (state != ST_RUN) && start_zero;
   endsequence

   // A software load, which also stops the timer
   sequence s_load_seen;
      cmd.load;
   endsequence

   // Counting is confined to the run state
   a_no_early_count: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (state != ST_RUN && !cmd.load) |=> $stable(count))
      else $error("count moved while not running");
   // Accepted start enters the run state next cycle
   a_start_runs: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_start_taken |=> (state == ST_RUN))
      else $error("start not taken");
   // Zero count start is ignored
   a_start_zero_ignored: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_start_refused |=> (state != ST_RUN))
      else $error("start with zero count taken");
   // Load places the preload and leaves the timer idle
   a_load_value: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_load_seen |=> (count == $past(cmd.preload)) && (state == ST_IDLE))
      else $error("load did not take the preload");
   // Each tick takes exactly one off the count
   a_step_by_one: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (tick && !cmd.load && count != COUNT_ZERO) |=>
      count == $past(count) - COUNT_ONE)
      else $error("count did not step by one");
   // Ticks never fall on consecutive cycles unless the divider is one
   a_divider_gap: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      tick |=> !tick || (count_clock_divider == 1))
      else $error("ticks closer than divider");
   // Running output is high only when the run state was held the cycle before
   a_running_state: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      running |-> ($past(state) == ST_RUN))
      else $error("running without run state");
   // Zero is held, never wrapped
   a_no_wrap: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (count == COUNT_ZERO && !cmd.load) |=> count == COUNT_ZERO)
      else $error("count wrapped below zero");
   // Final tick in count-down mode raises the flag
   a_underflow_set: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (s_last_tick and (mode == MODE_COUNT_DOWN)) |=>
      processor_status_word[UNDERFLOW_BIT])
      else $error("underflow flag not set");
   // Clear without a new underflow drops the flag
   a_flag_clear: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (underflow_clear && !set_underflow) |=>
      !processor_status_word[UNDERFLOW_BIT])
      else $error("underflow flag not cleared");
   // No status bit other than the underflow bit is ever set
   a_status_bits: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (processor_status_word & ~UNDERFLOW_MASK) == '0)
      else $error("stray status word bit");
   // Final tick in interrupt mode raises the interrupt
   a_irq_on_zero: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (s_last_tick and (mode == MODE_INTERRUPT)) |=> timer_irq)
      else $error("interrupt missing at zero");
   // Interrupt is a single-cycle pulse
   a_irq_one_cycle: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      timer_irq |=> !timer_irq)
      else $error("interrupt longer than one cycle");
   // Interrupt only from interrupt mode
   a_irq_mode_only: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      timer_irq |-> $past(mode) == MODE_INTERRUPT)
      else $error("interrupt in count-down mode");
   // Expired timer needs a reload before it runs again
   a_expired_hold: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (state == ST_EXPIRED && !cmd.load) |=> state != ST_RUN)
      else $error("expired timer restarted without reload");
endmodule : down_timer
`default_nettype wire

//--- shared/down_timer_pkg.sv
// Constants and carrier types for the core's built-in down timer.
// Assumes one core clock domain; no software-visible bus.
package down_timer_pkg;
   localparam int COUNT_WIDTH = 32;
   localparam int DIVIDER_DEFAULT = 1;
   localparam int UNDERFLOW_BIT = 12;
   localparam int STATUS_WIDTH = 32;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 32'h0000_0001;

   typedef enum logic [0:0] {
      MODE_COUNT_DOWN = 1'b0,
      MODE_INTERRUPT = 1'b1
   } timer_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_EXPIRED = 2'b10
   } timer_state_t;

   // Software command: preload value, load strobe, start strobe, mode
   typedef struct packed {
      logic [COUNT_WIDTH-1:0] preload;
      logic load;
      logic start;
      timer_mode_t mode;
   } timer_cmd_t;
endpackage : down_timer_pkg

//--- tb/down_timer_tb.sv
// Self-checking bench for the core's built-in down timer.
// Main dut uses the default divider, one decrement per ref_clk cycle; dut3 uses a divider of three.
`timescale 1ns/1ps
`default_nettype none
module down_timer_tb;
   import down_timer_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   timer_cmd_t cmd = '0;
   logic underflow_clear = 1'b0;
   logic [COUNT_WIDTH-1:0] count;
   logic running;
   logic [STATUS_WIDTH-1:0] processor_status_word;
   logic timer_irq;
   // Second timer with a divider of three, same commands
   logic [COUNT_WIDTH-1:0] count3;
   logic running3;
   logic [STATUS_WIDTH-1:0] status3;
   logic irq3;
   int errors = 0;
   int num_checks = 0;
   down_timer dut (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd),
      .underflow_clear(underflow_clear), .count(count),
      .running(running), .timer_irq(timer_irq),
      .processor_status_word(processor_status_word));
   down_timer #(.count_clock_divider(3)) dut3 (.ref_clk(ref_clk),
      .nrst(nrst), .cmd(cmd), .underflow_clear(underflow_clear),
      .count(count3), .running(running3), .timer_irq(irq3),
      .processor_status_word(status3));
   // Clock, 8 ns period
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // One cycle, inputs change just after the edge
   task cyc();
      @(posedge ref_clk);
      #1;
   endtask : cyc
   task chk(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   // Load a value and mode, then pulse start two cycles later
   task load_start(logic [31:0] v, timer_mode_t m);
      cmd.preload = v;
      cmd.mode = m;
      cmd.load = 1'b1;
      cyc();
      cmd.load = 1'b0;
      cyc();
      cmd.start = 1'b1;
      cyc();
      cmd.start = 1'b0;
   endtask : load_start
   // Bounded wait for the interrupt or the underflow flag
   task wait_end();
      int i;
      for (i = 0; i < 40; i++) begin
         if (timer_irq === 1'b1 ||
            processor_status_word[UNDERFLOW_BIT] === 1'b1) break;
         cyc();
      end
      if (i == 40) begin
         errors++;
         stop_test();
      end
   endtask : wait_end
   task irq_mode();
      load_start(32'h0000_0003, MODE_INTERRUPT);
      cyc();
      cyc();
      chk("running", {31'h0, running}, 32'h1);
      wait_end();
      chk("count", count, 32'h0);
      chk("psw", processor_status_word, 32'h0);
      cyc();
      chk("irq", {31'h0, timer_irq}, 32'h0);
      cmd.start = 1'b1;
      cyc();
      cmd.start = 1'b0;
      cyc();
      chk("restart", {31'h0, running}, 32'h0);
   endtask : irq_mode
   task cd_mode();
      load_start(32'h0000_0002, MODE_COUNT_DOWN);
      wait_end();
      chk("irq", {31'h0, timer_irq}, 32'h0);
      repeat (5) cyc();
      chk("count", count, 32'h0);
      chk("psw", processor_status_word, 32'h0000_1000);
      underflow_clear = 1'b1;
      cyc();
      underflow_clear = 1'b0;
      cyc();
      chk("psw clr", processor_status_word, 32'h0);
   endtask : cd_mode
   // Load with start in one cycle stops a running timer
   task load_stop();
      load_start(32'h0000_0010, MODE_INTERRUPT);
      cyc();
      chk("run before", {31'h0, running}, 32'h1);
      cmd.preload = 32'h0000_0007;
      cmd.load = 1'b1;
      cmd.start = 1'b1;
      cyc();
      cmd.load = 1'b0;
      cmd.start = 1'b0;
      cyc();
      chk("stopped", {31'h0, running}, 32'h0);
      chk("reloaded", count, 32'h0000_0007);
      repeat (3) cyc();
      chk("held", count, 32'h0000_0007);
      chk("no irq", {31'h0, timer_irq}, 32'h0);
   endtask : load_stop
   // Divider of three: one decrement every third cycle
   task div_three();
      load_start(32'h0000_0005, MODE_COUNT_DOWN);
      cyc();
      cyc();
      chk("div hold", count3, 32'h0000_0005);
      cyc();
      chk("div step1", count3, 32'h0000_0004);
      repeat (3) cyc();
      chk("div step2", count3, 32'h0000_0003);
   endtask : div_three
   // Main sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      chk("count rst", count, 32'h0);
      irq_mode();
      cd_mode();
      load_stop();
      div_three();
      stop_test();
   end
endmodule : down_timer_tb
`default_nettype wire
